// ### lvic_top.sv
// Low-voltage detector control and interrupt request/enable registers behind a Wishbone slave.
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
module lvic_top #(
    parameter int DELAY_CYC = lvic_pkg::LVIC_REQ_DELAY_CYC
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Analog detector interface.
    input wire logic lvd_cmp_i,
    output logic lvd_on_o,
    output logic [2:0] trip_level_o,
    // Power mode from the core.
    input wire logic sleep_i,
    input wire logic idle_i,
    // Interrupt sources.
    input wire logic [1:0] ext_pin_i,
    input wire lvic_pkg::lvic_src_s src_i,
    // Core service interface.
    input wire logic irq_ack_i,
    output logic irq_o,
    output logic [10:0] irq_pend_o,
    output logic wake_o
);

    // ------------------------------------------------------------
    // Register state.
    // ------------------------------------------------------------
    logic [2:0] trip_level_select_r;
    logic detector_on_r;
    logic [3:0] edge_sel_r;
    logic global_irq_en_r;
    logic [10:0] pri_en_r;
    logic [10:0] pri_flag_r;
    logic [7:0] mem_en_r;
    logic [7:0] mem_flag_r;
    logic ack_r;
    logic [31:0] dat_r;

    // ------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------
    logic req;
    logic wr;
    logic rd_take;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic wr_lv;
    logic wr_edge;
    logic [2:0] wr_pri;
    logic [2:0] wr_grp;

    // The request is acked one cycle after it appears; writes land on the acking edge.
    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & ack_r & wb_sel_i[0];
    assign rd_take = req & ~ack_r;
    assign wbyte = wb_dat_i[7:0];
    assign wr_lv = wr & (wb_adr_i == lvic_pkg::LVIC_OFS_LVCTL);
    assign wr_edge = wr & (wb_adr_i == lvic_pkg::LVIC_OFS_EDGE);
    assign wr_pri[0] = wr & (wb_adr_i == lvic_pkg::LVIC_OFS_PRI0);
    assign wr_pri[1] = wr & (wb_adr_i == lvic_pkg::LVIC_OFS_PRI1);
    assign wr_pri[2] = wr & (wb_adr_i == lvic_pkg::LVIC_OFS_PRI2);
    assign wr_grp[0] = wr & (wb_adr_i == lvic_pkg::LVIC_OFS_GRP0);
    assign wr_grp[1] = wr & (wb_adr_i == lvic_pkg::LVIC_OFS_GRP1);
    assign wr_grp[2] = wr & (wb_adr_i == lvic_pkg::LVIC_OFS_GRP2);

    // Ack drops the cycle after it was given, so back-to-back requests see a gap.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // ------------------------------------------------------------
    // Detector control and synchronised comparator.
    // ------------------------------------------------------------
    logic cmp_s1_r;
    logic cmp_s2_r;
    logic det_active;
    logic status;

    // Threshold and enable are plain software fields.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trip_level_select_r <= lvic_pkg::LVIC_TRIP_RST;
            detector_on_r <= 1'b0;
        end else if (wr_lv) begin
            trip_level_select_r <= wbyte[lvic_pkg::LVIC_TRIP_LSB +: 3];
            detector_on_r <= wbyte[lvic_pkg::LVIC_ON_BIT];
        end
    end

    // The comparator output is asynchronous to this clock.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
        end else begin
            cmp_s1_r <= lvd_cmp_i;
            cmp_s2_r <= cmp_s1_r;
        end
    end

    // Sleep overrides the enable; a powered-down comparator reports no low supply.
    assign det_active = detector_on_r & ~sleep_i;
    assign status = det_active & cmp_s2_r;
    assign lvd_on_o = det_active;
    assign trip_level_o = trip_level_select_r;

    // ------------------------------------------------------------
    // Low-voltage request delay.
    // ------------------------------------------------------------
    lvic_pkg::lvic_dly_e dly_state_r;
    logic [15:0] dly_cnt_r;
    logic lv_set;

    // Status can bounce near the threshold, so each drop cancels and restarts the wait.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_state_r <= lvic_pkg::LVIC_DLY_IDLE;
            dly_cnt_r <= 16'h0000;
        end else begin
            case (dly_state_r)
                lvic_pkg::LVIC_DLY_IDLE: begin
                    dly_cnt_r <= 16'h0000;
                    if (status) begin
                        dly_state_r <= lvic_pkg::LVIC_DLY_WAIT;
                    end
                end
                lvic_pkg::LVIC_DLY_WAIT: begin
                    if (!status) begin
                        dly_state_r <= lvic_pkg::LVIC_DLY_IDLE;
                    end else if (lv_set) begin
                        dly_state_r <= lvic_pkg::LVIC_DLY_HELD;
                    end else begin
                        dly_cnt_r <= dly_cnt_r + 16'h0001;
                    end
                end
                lvic_pkg::LVIC_DLY_HELD: begin
                    if (!status) begin
                        dly_state_r <= lvic_pkg::LVIC_DLY_IDLE;
                    end
                end
                default: begin
                    dly_state_r <= lvic_pkg::LVIC_DLY_IDLE;
                end
            endcase
        end
    end

    // One request per low episode, raised when the wait completes with status still high.
    assign lv_set = (dly_state_r == lvic_pkg::LVIC_DLY_WAIT) & status
        & (dly_cnt_r == 16'(DELAY_CYC - 1));

    // ------------------------------------------------------------
    // External pins and edge select.
    // ------------------------------------------------------------
    logic [1:0] pin_edge;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_sel_r <= lvic_pkg::LVIC_EDGE_RST;
        end else if (wr_edge) begin
            edge_sel_r <= wbyte[3:0];
        end
    end

    lvic_pin_edge #(
        .N(2)
    ) u_pin_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext_pin_i),
        .sel_i(edge_sel_r),
        .edge_o(pin_edge)
    );

    // ------------------------------------------------------------
    // Request flags and enables.
    // ------------------------------------------------------------
    logic [7:0] mem_evt;
    logic [7:0] mem_wmask;
    logic [7:0] mem_wen;
    logic [7:0] mem_wflag;
    logic [2:0] grp_any;
    logic [10:0] pri_evt;
    logic [10:0] pri_wmask;
    logic [10:0] pri_wen;
    logic [10:0] pri_wflag;

    // Group members: three timers P/A, the delayed low-voltage request and the nvm source.
    assign mem_evt = {src_i.nvm, lv_set, src_i.tmr};
    assign mem_wmask = {{2{wr_grp[2]}}, {4{wr_grp[1]}}, {2{wr_grp[0]}}};
    assign mem_wen = {wbyte[1:0], wbyte[3:0], wbyte[1:0]};
    assign mem_wflag = {wbyte[5:4], wbyte[7:4], wbyte[5:4]};

    // A group keeps asking while any enabled member is pending.
    assign grp_any[0] = |(mem_en_r[1:0] & mem_flag_r[1:0]);
    assign grp_any[1] = |(mem_en_r[5:2] & mem_flag_r[5:2]);
    assign grp_any[2] = |(mem_en_r[7:6] & mem_flag_r[7:6]);

    assign pri_evt = {src_i.uart, src_i.sim, pin_edge[1], src_i.tb1, src_i.tb0, src_i.adc,
        grp_any, src_i.cmp, pin_edge[0]};
    assign pri_wmask = {{4{wr_pri[2]}}, {4{wr_pri[1]}}, {3{wr_pri[0]}}};
    assign pri_wen = {wbyte[3:0], wbyte[3:0], wbyte[3:1]};
    assign pri_wflag = {wbyte[7:4], wbyte[7:4], wbyte[6:4]};

    // A hardware event in the same cycle as a software clear wins, so no request is lost.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_en_r <= lvic_pkg::LVIC_MEM_RST;
            mem_flag_r <= lvic_pkg::LVIC_MEM_RST;
        end else begin
            mem_en_r <= (mem_wmask & mem_wen) | (~mem_wmask & mem_en_r);
            mem_flag_r <= (mem_wmask & mem_wflag) | (~mem_wmask & mem_flag_r) | mem_evt;
        end
    end

    // Flags record requests whether or not enables or the global enable are set.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pri_en_r <= lvic_pkg::LVIC_PRI_RST;
            pri_flag_r <= lvic_pkg::LVIC_PRI_RST;
        end else begin
            pri_en_r <= (pri_wmask & pri_wen) | (~pri_wmask & pri_en_r);
            pri_flag_r <= (pri_wmask & pri_wflag) | (~pri_wmask & pri_flag_r) | pri_evt;
        end
    end

    // Service entry clears the global enable; it beats a software set in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            global_irq_en_r <= 1'b0;
        end else if (irq_ack_i) begin
            global_irq_en_r <= 1'b0;
        end else if (wr_pri[0]) begin
            global_irq_en_r <= wbyte[lvic_pkg::LVIC_GLB_BIT];
        end
    end

    // ------------------------------------------------------------
    // Request and wake outputs.
    // ------------------------------------------------------------
    logic [10:0] pend;

    assign pend = pri_en_r & pri_flag_r;

    // Registered so the core sees a clean level; vector choice is left to the core.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
            irq_pend_o <= 11'h000;
        end else begin
            irq_o <= global_irq_en_r & (|pend);
            irq_pend_o <= global_irq_en_r ? pend : 11'h000;
        end
    end

    // Wake follows the flag being set by the detector, so a flag preset by software stays quiet.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= idle_i & lv_set & ~mem_flag_r[lvic_pkg::LVIC_M_LV];
        end
    end

    // ------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------
    // Unmapped addresses and unimplemented bits read zero.
    always_comb begin
        rbyte = 8'h00;
        case (wb_adr_i)
            lvic_pkg::LVIC_OFS_LVCTL: rbyte = {2'b00, status, detector_on_r, 1'b0, trip_level_select_r};
            lvic_pkg::LVIC_OFS_EDGE: rbyte = {4'h0, edge_sel_r};
            lvic_pkg::LVIC_OFS_PRI0: rbyte = {1'b0, pri_flag_r[2:0], pri_en_r[2:0], global_irq_en_r};
            lvic_pkg::LVIC_OFS_PRI1: rbyte = {pri_flag_r[6:3], pri_en_r[6:3]};
            lvic_pkg::LVIC_OFS_PRI2: rbyte = {pri_flag_r[10:7], pri_en_r[10:7]};
            lvic_pkg::LVIC_OFS_GRP0: rbyte = {2'b00, mem_flag_r[1:0], 2'b00, mem_en_r[1:0]};
            lvic_pkg::LVIC_OFS_GRP1: rbyte = {mem_flag_r[5:2], mem_en_r[5:2]};
            lvic_pkg::LVIC_OFS_GRP2: rbyte = {2'b00, mem_flag_r[7:6], 2'b00, mem_en_r[7:6]};
            default: rbyte = 8'h00;
        endcase
    end

    // Captured as the ack rises and held while it stands.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (rd_take) begin
            dat_r <= {24'h00_0000, rbyte};
        end
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    logic [15:0] hi_run_r;

    // Length of the current unbroken low-supply run, saturating.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hi_run_r <= 16'h0000;
        end else if (!status) begin
            hi_run_r <= 16'h0000;
        end else if (hi_run_r != 16'hffff) begin
            hi_run_r <= hi_run_r + 16'h0001;
        end
    end

    a_trip_level_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_lv |=> trip_level_o == $past(wb_dat_i[2:0]))
        else $error("trip level not taken from write");

    a_status_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_take && wb_adr_i == lvic_pkg::LVIC_OFS_LVCTL) |=> wb_dat_o[5] == $past(status))
        else $error("status bit read wrong");

    a_sleep_forces_off: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_i |-> !lvd_on_o && !status)
        else $error("detector on during sleep");

    a_req_after_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        lv_set |-> hi_run_r >= 16'(DELAY_CYC - 1) && status)
        else $error("low-voltage request before delay");

    a_req_into_group: assert property (@(posedge clk_i) disable iff (rst_i)
        lv_set |=> mem_flag_r[lvic_pkg::LVIC_M_LV])
        else $error("low-voltage flag not set");

    a_idle_wakeup: assert property (@(posedge clk_i) disable iff (rst_i)
        (lv_set && idle_i && !mem_flag_r[lvic_pkg::LVIC_M_LV]) |=> wake_o)
        else $error("no wake from idle");

    a_zero_bits: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_ack_o && wb_adr_i == lvic_pkg::LVIC_OFS_LVCTL) |-> wb_dat_o[7:6] == 2'b00 && !wb_dat_o[3])
        else $error("unimplemented bit reads one");

    a_global_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
        !global_irq_en_r |=> !irq_o && irq_pend_o == 11'h000)
        else $error("request while globally disabled");

    a_service_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_ack_i |=> !global_irq_en_r)
        else $error("global enable survived service entry");

    a_group_raise: assert property (@(posedge clk_i) disable iff (rst_i)
        grp_any[2] |=> pri_flag_r[lvic_pkg::LVIC_P_GRP2])
        else $error("group flag not raised");

    a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        (pri_evt[lvic_pkg::LVIC_P_CMP] && wr_pri[0] && !wbyte[5]) |=> pri_flag_r[lvic_pkg::LVIC_P_CMP])
        else $error("event lost against clear");

endmodule : lvic_top

// ### lvic_pkg.sv
// Constants, types and register map of the low-voltage and interrupt control block.
//
// Behaviour
// - Three-bit code picks one of eight trip levels.
// - Status bit 5 shows supply low, read-only.
// - Enable bit 4 powers detector, resets low.
// - Sleep forces the detector off regardless of enable.
// - Status may toggle repeatedly near the threshold.
// - Low-voltage flag sets only after fixed delay.
// - Low-voltage request feeds multi-function group two.
// - Pending low-voltage request wakes device from idle; here only when the detector sets a clear flag.
// - Two pins plus internal sources raise requests.
// - Every source has own enable and flag.
// - Primary byte zero: global, three enables, flags.
// - Primary bytes one, two: four enables, flags.
// - Group bytes zero, two: two enables, flags.
// - Group byte one: four timer enables, flags.
// - Two-bit edge select per external pin.
// - Unimplemented bits read zero; edge register resets zero.
// - Flag interrupts only when enabled and global set.
// - Service entry clears global enable; flags still record.
// - Flags and enables are read-write, reset zero.
package lvic_pkg;

    // ------------------------------------------------------------
    // Register byte offsets on the bus.
    // ------------------------------------------------------------
    localparam logic [7:0] LVIC_OFS_LVCTL = 8'h00;
    localparam logic [7:0] LVIC_OFS_EDGE = 8'h04;
    localparam logic [7:0] LVIC_OFS_PRI0 = 8'h08;
    localparam logic [7:0] LVIC_OFS_PRI1 = 8'h0c;
    localparam logic [7:0] LVIC_OFS_PRI2 = 8'h10;
    localparam logic [7:0] LVIC_OFS_GRP0 = 8'h14;
    localparam logic [7:0] LVIC_OFS_GRP1 = 8'h18;
    localparam logic [7:0] LVIC_OFS_GRP2 = 8'h1c;

    // ------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------
    localparam int LVIC_TRIP_LSB = 0;
    localparam int LVIC_ON_BIT = 4;
    localparam int LVIC_STAT_BIT = 5;
    localparam int LVIC_GLB_BIT = 0;

    // Primary source index, same order as the bits of the three primary bytes.
    localparam int LVIC_P_PIN0 = 0;
    localparam int LVIC_P_CMP = 1;
    localparam int LVIC_P_GRP0 = 2;
    localparam int LVIC_P_GRP1 = 3;
    localparam int LVIC_P_GRP2 = 4;
    localparam int LVIC_P_ADC = 5;
    localparam int LVIC_P_TB0 = 6;
    localparam int LVIC_P_TB1 = 7;
    localparam int LVIC_P_PIN1 = 8;
    localparam int LVIC_P_SIM = 9;
    localparam int LVIC_P_UART = 10;
    localparam int LVIC_NPRI = 11;

    // Group member index: timer zero P/A, timer one P/A, timer two P/A, low voltage, nvm.
    localparam int LVIC_M_LV = 6;
    localparam int LVIC_M_NVM = 7;
    localparam int LVIC_NMEM = 8;

    // ------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------
    localparam logic [2:0] LVIC_TRIP_RST = 3'h0;
    localparam logic [3:0] LVIC_EDGE_RST = 4'h0;
    localparam logic [10:0] LVIC_PRI_RST = 11'h000;
    localparam logic [7:0] LVIC_MEM_RST = 8'h00;

    // ------------------------------------------------------------
    // Encodings.
    // ------------------------------------------------------------
    localparam logic [2:0] LVIC_TRIP_1V8 = 3'h0;
    localparam logic [2:0] LVIC_TRIP_4V0 = 3'h7;
    localparam logic [1:0] LVIC_EDGE_OFF = 2'h0;
    localparam logic [1:0] LVIC_EDGE_RISE = 2'h1;
    localparam logic [1:0] LVIC_EDGE_FALL = 2'h2;
    localparam logic [1:0] LVIC_EDGE_BOTH = 2'h3;

    // ------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------
    localparam int LVIC_CLK_PERIOD_NS = 50;
    localparam int LVIC_REQ_DELAY_NS = 15000;
    localparam int LVIC_REQ_DELAY_CYC = (LVIC_REQ_DELAY_NS + LVIC_CLK_PERIOD_NS - 1) / LVIC_CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LVIC_DLY_IDLE = 2'b00,
        LVIC_DLY_WAIT = 2'b01,
        LVIC_DLY_HELD = 2'b10
    } lvic_dly_e;

    // One-cycle event pulses from the internal sources.
    typedef struct packed {
        logic uart;
        logic sim;
        logic tb1;
        logic tb0;
        logic adc;
        logic cmp;
        logic nvm;
        logic [5:0] tmr;
    } lvic_src_s;

endpackage : lvic_pkg

// ### lvic_pin_edge.sv
// Synchroniser and selectable edge detector for the external interrupt pins.
module lvic_pin_edge #(
    parameter int N = 2
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Raw pins and two select bits per pin.
    input wire logic [N-1:0] pin_i,
    input wire logic [2*N-1:0] sel_i,
    // One-cycle edge pulses.
    output logic [N-1:0] edge_o
);

    // ------------------------------------------------------------
    // Per-pin logic.
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            logic s1_r;
            logic s2_r;
            logic prev_r;
            logic rise;
            logic fall;
            // Two flops before any logic; only the second stage and later are looked at.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    prev_r <= 1'b0;
                end else begin
                    s1_r <= pin_i[g];
                    s2_r <= s1_r;
                    prev_r <= s2_r;
                end
            end
            // Code 00 keeps the pin silent, bit 0 picks rising and bit 1 falling edges.
            assign rise = s2_r & ~prev_r;
            assign fall = ~s2_r & prev_r;
            assign edge_o[g] = (sel_i[2*g] & rise) | (sel_i[2*g+1] & fall);

            a_edge_select: assert property (@(posedge clk_i) disable iff (rst_i)
                (sel_i[2*g+1 -: 2] == lvic_pkg::LVIC_EDGE_OFF) |-> !edge_o[g])
                else $error("edge pulse while pin disabled");
        end
    endgenerate

endmodule : lvic_pin_edge

// ### lvic_core_model.sv
// Behavioural processor core that answers interrupt requests after a chosen latency.
module lvic_core_model (
    // Clock, reset and latency.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] lat_i,
    // Service handshake.
    input wire logic irq_i,
    output logic irq_ack_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_r;
    // Count while a request stands, then enter service with a single pulse.
    always_ff @(posedge clk_i) begin
        if (rst_i || !irq_i || irq_ack_o) begin
            wait_r <= 4'h0;
            irq_ack_o <= 1'b0;
        end else if (wait_r == lat_i) begin
            irq_ack_o <= 1'b1;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule : lvic_core_model

// ### low_voltage_and_irq_control_test.sv
// Self-checking bench for the low-voltage and interrupt control block.
module low_voltage_and_irq_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int D = 4;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, cmp = 1'b0, on, slp = 1'b0, idl = 1'b0;
    logic irq, ack_c, wake;
    logic [7:0] adr = 8'h00, q;
    logic [31:0] wd = 32'h0, rdat;
    logic [2:0] trip;
    logic [1:0] pin = 2'h0;
    logic [3:0] lat = 4'h3;
    logic [10:0] pend;
    lvic_pkg::lvic_src_s src = '0;
    int fail_count = 0, n_compared = 0, n;
    lvic_top #(.DELAY_CYC(D)) u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .lvd_cmp_i(cmp),
        .lvd_on_o(on), .trip_level_o(trip), .sleep_i(slp), .idle_i(idl), .ext_pin_i(pin), .src_i(src),
        .irq_ack_i(ack_c), .irq_o(irq), .irq_pend_o(pend), .wake_o(wake));
    lvic_core_model u_core (.clk_i(clk), .rst_i(rst), .lat_i(lat), .irq_i(irq), .irq_ack_o(ack_c));
    // Free-running 20 MHz clock.
    initial begin
        forever #25 clk = ~clk;
    end
    // Verdict; the single place where the run ends.
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Classic single cycle; the request is held until ack is sampled high.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {1'b1, 1'b1, w, a, 24'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            fail_count++;
            final_report();
        end
        q = rdat[7:0];
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk({24'h0, q}, {24'h0, e});
    endtask : rd
    task automatic pins(input logic [1:0] v);
        pin <= v;
        repeat (8) @(posedge clk);
    endtask : pins
    // Waits for a level on a design flag, with a bound.
    task automatic wait_on(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk(n < 100, 1'b1);
    endtask : wait_on
    // ----------------------------------------
    // Scenarios.
    // ----------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 9; i++) rd(8'(i * 4), 8'h00);
        $display("reset values done");
    endtask : t_reset
    task automatic t_lvctl;
        bus(1'b1, lvic_pkg::LVIC_OFS_LVCTL, 8'hff);
        rd(lvic_pkg::LVIC_OFS_LVCTL, 8'h17);
        chk(trip, lvic_pkg::LVIC_TRIP_4V0);
        chk(on, 1'b1);
        slp <= 1'b1;
        @(posedge clk);
        chk(on, 1'b0);
        slp <= 1'b0;
        bus(1'b1, lvic_pkg::LVIC_OFS_LVCTL, 8'h00);
        chk(trip, lvic_pkg::LVIC_TRIP_1V8);
        $display("detector control done");
    endtask : t_lvctl
    task automatic t_edge;
        bus(1'b1, lvic_pkg::LVIC_OFS_EDGE, 8'hf6);
        rd(lvic_pkg::LVIC_OFS_EDGE, 8'h06);
        pins(2'h3);
        rd(lvic_pkg::LVIC_OFS_PRI0, 8'h00);
        rd(lvic_pkg::LVIC_OFS_PRI2, 8'h20);
        pins(2'h0);
        rd(lvic_pkg::LVIC_OFS_PRI0, 8'h10);
        bus(1'b1, lvic_pkg::LVIC_OFS_PRI0, 8'h00);
        bus(1'b1, lvic_pkg::LVIC_OFS_PRI2, 8'h00);
        bus(1'b1, lvic_pkg::LVIC_OFS_EDGE, 8'h0c);
        pins(2'h3);
        pins(2'h0);
        rd(lvic_pkg::LVIC_OFS_PRI0, 8'h00);
        rd(lvic_pkg::LVIC_OFS_PRI2, 8'h20);
        $display("edge select done");
    endtask : t_edge
    task automatic t_irq;
        // The comparator event lands on the acking edge of a write that clears its flag.
        fork
            bus(1'b1, lvic_pkg::LVIC_OFS_PRI0, 8'h05);
            begin
                repeat (2) @(posedge clk);
                src.cmp <= 1'b1;
                @(posedge clk);
                src.cmp <= 1'b0;
            end
        join
        wait_on(irq, 1'b1);
        chk(pend, 11'h002);
        wait_on(irq, 1'b0);
        rd(lvic_pkg::LVIC_OFS_PRI0, 8'h24);
        $display("service entry done");
    endtask : t_irq
    task automatic t_lv;
        lat <= 4'h0;
        bus(1'b1, lvic_pkg::LVIC_OFS_GRP2, 8'h01);
        bus(1'b1, lvic_pkg::LVIC_OFS_PRI1, 8'h02);
        bus(1'b1, lvic_pkg::LVIC_OFS_LVCTL, 8'h10);
        idl <= 1'b1;
        cmp <= 1'b1;
        repeat (3) @(posedge clk);
        cmp <= 1'b0;
        repeat (3) @(posedge clk);
        cmp <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wake !== 1'b1 && n < 50);
        chk(n >= D + 3 && n <= D + 5, 1'b1);
        rd(lvic_pkg::LVIC_OFS_LVCTL, 8'h30);
        rd(lvic_pkg::LVIC_OFS_GRP2, 8'h11);
        rd(lvic_pkg::LVIC_OFS_PRI1, 8'h22);
        $display("low-voltage request done");
    endtask : t_lv
    // Software presets the flag before a new low episode, so idle must not be left.
    task automatic t_preset;
        cmp <= 1'b0;
        bus(1'b1, lvic_pkg::LVIC_OFS_GRP2, 8'h11);
        cmp <= 1'b1;
        n = 0;
        repeat (D + 8) begin
            @(posedge clk);
            if (wake !== 1'b0) n++;
        end
        chk(n, 0);
        rd(lvic_pkg::LVIC_OFS_GRP2, 8'h11);
        $display("preset flag done");
    endtask : t_preset
    // Reset for 12 cycles, then the scenarios in turn.
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_lvctl();
        t_edge();
        t_irq();
        t_lv();
        t_preset();
        final_report();
    end
endmodule : low_voltage_and_irq_control_test
